/* File: design/test_frame_fifo.sv */
// Byte FIFO between the frame builder and the media transmit path.
// Assumes one clock; the drain side may stall through out_ready_i.
module test_frame_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_q, rd_q;
  wire full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  wire empty = (wr_q == rd_q);
  wire push = in_valid_i && !full;
  wire pop = out_ready_i && !empty;
  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign out_data_o = mem[rd_q[AW-1:0]];
  // Storage write
  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem[wr_q[AW-1:0]] <= in_data_i;
    end
  end
  // Pointers
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_q + (AW+1)'(push);
      rd_q <= rd_q + (AW+1)'(pop);
    end
  end
endmodule

/* File: design/test_frame_pkg.sv */
// Package for the built-in test frame source: register map, fields, timing.
// Assumes a 25 MHz core clock and a management-register write/read port.
package test_frame_pkg;
  // Management addresses and page codes
  localparam logic [4:0] ADDR_PAGE_SEL = 5'h1f;
  localparam logic [4:0] ADDR_CTRL = 5'h1d;
  localparam logic [4:0] ADDR_PATTERN = 5'h1e;
  localparam logic [4:0] ADDR_EXT_LO = 5'h10;
  localparam logic [15:0] PAGE_MAIN = 16'h0000;
  localparam logic [15:0] PAGE_EXT1 = 16'h0001;
  localparam logic [15:0] PAGE_EXT2 = 16'h0002;
  localparam logic [15:0] PAGE_EXT3 = 16'h0003;
  // Control register fields and reset values
  localparam int CTRL_EN = 15;
  localparam int CTRL_RUN = 14;
  localparam int CTRL_CONT = 13;
  localparam int CTRL_LEN_HI = 12;
  localparam int CTRL_LEN_LO = 11;
  localparam int CTRL_GAP = 10;
  localparam int CTRL_DA_HI = 9;
  localparam int CTRL_DA_LO = 6;
  localparam int CTRL_SA_HI = 5;
  localparam int CTRL_SA_LO = 2;
  localparam int CTRL_RAND = 1;
  localparam int CTRL_BADFCS = 0;
  localparam logic [15:0] CTRL_RESET = 16'h0040;
  localparam logic [15:0] PATTERN_RESET = 16'h0000;
  // Frame sizes in bytes, preamble and header lengths
  localparam logic [13:0] LEN_125 = 14'h007d;
  localparam logic [13:0] LEN_64 = 14'h0040;
  localparam logic [13:0] LEN_1518 = 14'h05ee;
  localparam logic [13:0] LEN_JUMBO = 14'h2710;
  localparam logic [13:0] HDR_BYTES = 14'h000c;
  localparam logic [13:0] FCS_BYTES = 14'h0004;
  localparam logic [3:0] PREAMBLE_BYTES = 4'h8;
  // Counts of packets
  localparam logic [13:0] BLOCK_PKTS = 14'h2710;
  localparam int BURST_PKTS = 30000000;
  // Gap timing, CRC, preamble and LFSR constants
  localparam int CLK_MHZ = 25;
  localparam int GAP_LONG_NS = 8192;
  localparam int GAP_SHORT_NS = 96;
  localparam int GAP_LONG_CYC = (GAP_LONG_NS * CLK_MHZ + 999) / 1000;
  localparam int GAP_SHORT_CYC = (GAP_SHORT_NS * CLK_MHZ + 999) / 1000;
  localparam logic [31:0] CRC_INIT = 32'hffffffff;
  localparam logic [31:0] CRC_POLY = 32'hedb88320;
  localparam logic [7:0] SFD_BYTE = 8'hd5;
  localparam logic [7:0] PRE_BYTE = 8'h55;
  localparam logic [15:0] LFSR_SEED = 16'hace1;
  // Management write command
  typedef struct packed {
    logic [4:0] addr;
    logic [15:0] data;
  } mgmt_wr_s;
  // Media byte with low power idle flag
  typedef struct packed {
    logic [7:0] data;
    logic low_power_idle;
  } media_byte_s;
endpackage

/* File: design/test_frame_source.sv */
// Test frame source with its management registers and page selection.
// Assumes management writes/reads arrive as one-cycle strobes on core_clk_i
// and the media side takes bytes with a valid/ready handshake.
//
// Functional notes
// - Send only while enable and run set; field changes apply on rerun, except clearing continuous.
// - Continuous mode sends nonstop, counting in blocks of 10000 packets.
// - Leaving continuous mode stops at next 10000-packet boundary.
// - Non-continuous mode sends exactly 30000000 packets then stops.
// - Length code picks 125, 64, 1518 or 10000 byte frames.
// - Gap select chooses 8192 ns or 96 ns between frames.
// - Destination address is all ones except selectable low nibble, default 1.
// - Source address is all ones except selectable low nibble, default 0.
// - Payload type chooses random pattern or fixed programmed pattern.
// - FCS control appends a deliberately wrong or a correct FCS.
// - Pattern register holds 16-bit payload word, reset zero.
// - Writing 2 to register 31 selects extended page 2.
// - Only addresses 16 to 30 are remapped by the page.
// - Writing 0 to register 31 restores main register space.
// - Writing 3 to register 31 selects extended page 3.
// - Force low power idle sends idle symbols instead of normal idles.
module test_frame_source #(
  parameter int BURST = test_frame_pkg::BURST_PKTS,
  parameter int GAP_LONG = test_frame_pkg::GAP_LONG_CYC,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic mgmt_wr_i,
  input wire logic [4:0] mgmt_addr_i,
  input wire logic [15:0] mgmt_wdata_i,
  output logic [15:0] mgmt_rdata_o,
  output logic [15:0] page_o,
  input wire logic force_lpi_i,
  output logic media_valid_o,
  output logic [7:0] media_data_o,
  output logic media_lpi_o,
  input wire logic media_ready_i,
  output logic busy_o
);
  typedef enum logic [2:0] {IDLE, PRE, HDR, PAY, FCS, GAP} st_e;
  st_e st_q, st_d;
  logic [15:0] ctrl_q, pat_q, page_q;
  logic [15:0] run_ctrl_q, run_pat_q;
  logic run_seen_q;
  logic [13:0] byte_q, flen_q;
  logic [31:0] crc_q, pkts_q;
  logic [13:0] blk_q;
  logic [15:0] lfsr_q;
  logic [13:0] gap_q;
  logic [8:0] fifo_in, fifo_out;
  logic fifo_ready, fifo_valid;
  logic out_valid_q, out_lpi_q;
  logic [7:0] out_data_q;

  // Byte-wise CRC-32 update, reflected form
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h000000, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ test_frame_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // Frame length from the length code
  function automatic logic [13:0] len_of(input logic [1:0] code);
    case (code)
      2'h0: return test_frame_pkg::LEN_125;
      2'h1: return test_frame_pkg::LEN_64;
      2'h2: return test_frame_pkg::LEN_1518;
      default: return test_frame_pkg::LEN_JUMBO;
    endcase
  endfunction

  // Register decode; page remaps only 16..30
  wire in_ext = mgmt_addr_i >= test_frame_pkg::ADDR_EXT_LO
                && mgmt_addr_i != test_frame_pkg::ADDR_PAGE_SEL;
  wire on_pg1 = page_q == test_frame_pkg::PAGE_EXT1;
  wire wr_page = mgmt_wr_i && mgmt_addr_i == test_frame_pkg::ADDR_PAGE_SEL;
  wire wr_ctrl = mgmt_wr_i && in_ext && on_pg1 && mgmt_addr_i == test_frame_pkg::ADDR_CTRL;
  wire wr_pat = mgmt_wr_i && in_ext && on_pg1 && mgmt_addr_i == test_frame_pkg::ADDR_PATTERN;
  wire [15:0] rd_val = (mgmt_addr_i == test_frame_pkg::ADDR_PAGE_SEL) ? page_q :
                       (in_ext && on_pg1 && mgmt_addr_i == test_frame_pkg::ADDR_CTRL) ? ctrl_q :
                       (in_ext && on_pg1 && mgmt_addr_i == test_frame_pkg::ADDR_PATTERN) ? pat_q :
                       16'h0000;

  // Management registers
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      ctrl_q <= test_frame_pkg::CTRL_RESET;
      pat_q <= test_frame_pkg::PATTERN_RESET;
      page_q <= test_frame_pkg::PAGE_MAIN;
      mgmt_rdata_o <= 16'h0000;
    end else begin
      if (wr_page) page_q <= mgmt_wdata_i;
      if (wr_ctrl) ctrl_q <= mgmt_wdata_i;
      if (wr_pat) pat_q <= mgmt_wdata_i;
      mgmt_rdata_o <= rd_val;
    end
  end

  wire go = ctrl_q[test_frame_pkg::CTRL_EN] && ctrl_q[test_frame_pkg::CTRL_RUN];
  wire start = go && !run_seen_q;
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      run_seen_q <= 1'b0;
      run_ctrl_q <= test_frame_pkg::CTRL_RESET;
      run_pat_q <= test_frame_pkg::PATTERN_RESET;
    end else begin
      run_seen_q <= go;
      if (start) begin
        run_ctrl_q <= ctrl_q;
        run_pat_q <= pat_q;
      end
    end
  end

  // Stop conditions
  // live continuous bit, block boundary
  wire cont_live = ctrl_q[test_frame_pkg::CTRL_CONT] && run_ctrl_q[test_frame_pkg::CTRL_CONT];
  wire at_block = blk_q == 14'h0000 && pkts_q != 32'h00000000;
  wire burst_done = !run_ctrl_q[test_frame_pkg::CTRL_CONT] && pkts_q >= 32'(BURST);
  wire block_done = run_ctrl_q[test_frame_pkg::CTRL_CONT] && !cont_live && at_block;
  wire stop_now = !go || burst_done || block_done;

  // Byte selection for the current frame position
  // all-ones addresses with low nibble
  wire [3:0] da_nib = run_ctrl_q[test_frame_pkg::CTRL_DA_HI:test_frame_pkg::CTRL_DA_LO];
  wire [3:0] sa_nib = run_ctrl_q[test_frame_pkg::CTRL_SA_HI:test_frame_pkg::CTRL_SA_LO];
  wire [7:0] hdr_byte = (byte_q == 14'h0005) ? {4'hf, da_nib} :
                        (byte_q == 14'h000b) ? {4'hf, sa_nib} : 8'hff;
  // random or fixed, high byte first
  wire [7:0] pay_byte = run_ctrl_q[test_frame_pkg::CTRL_RAND] ? lfsr_q[7:0] :
                        (byte_q[0] ? run_pat_q[7:0] : run_pat_q[15:8]);
  wire [31:0] fcs_val = run_ctrl_q[test_frame_pkg::CTRL_BADFCS] ? crc_q : ~crc_q;
  wire [7:0] fcs_byte = fcs_val[8*byte_q[1:0] +: 8];
  wire last_pre = byte_q == 14'(test_frame_pkg::PREAMBLE_BYTES - 4'h1);
  wire [7:0] pre_byte = last_pre ? test_frame_pkg::SFD_BYTE : test_frame_pkg::PRE_BYTE;
  wire [13:0] pay_len = flen_q - test_frame_pkg::HDR_BYTES - test_frame_pkg::FCS_BYTES;
  wire emitting = st_q == PRE || st_q == HDR || st_q == PAY || st_q == FCS;
  wire [7:0] cur_byte = (st_q == PRE) ? pre_byte : (st_q == HDR) ? hdr_byte :
                        (st_q == PAY) ? pay_byte : fcs_byte;
  wire step = emitting && fifo_ready;
  assign fifo_in = {cur_byte, 1'b0};

  always_comb begin
    st_d = st_q;
    case (st_q)
      IDLE: if (go && !stop_now && run_seen_q) st_d = PRE;
      PRE: if (step && last_pre) st_d = HDR;
      HDR: if (step && byte_q == test_frame_pkg::HDR_BYTES - 14'h0001) st_d = PAY;
      PAY: if (step && byte_q == pay_len - 14'h0001) st_d = FCS;
      FCS: if (step && byte_q == test_frame_pkg::FCS_BYTES - 14'h0001) st_d = GAP;
      GAP: if (gap_q == 14'h0000) st_d = IDLE;
      default: st_d = IDLE;
    endcase
    if (!go) st_d = IDLE;
  end

  // frame length and gap per frame
  wire [13:0] gap_load = run_ctrl_q[test_frame_pkg::CTRL_GAP] ? 14'(GAP_LONG - 1) :
                         14'(test_frame_pkg::GAP_SHORT_CYC - 1);
  wire leave = st_d != st_q;
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      st_q <= IDLE;
      byte_q <= 14'h0000;
      flen_q <= test_frame_pkg::LEN_125;
      gap_q <= 14'h0000;
    end else begin
      st_q <= st_d;
      byte_q <= leave ? 14'h0000 : (step ? byte_q + 14'h0001 : byte_q);
      if (st_q == IDLE) begin
        flen_q <= len_of(run_ctrl_q[test_frame_pkg::CTRL_LEN_HI:test_frame_pkg::CTRL_LEN_LO]);
      end
      gap_q <= (st_d == GAP && st_q != GAP) ? gap_load :
               (gap_q != 14'h0000 ? gap_q - 14'h0001 : gap_q);
    end
  end

  // CRC over header and payload, LFSR for random payload
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      crc_q <= test_frame_pkg::CRC_INIT;
      lfsr_q <= test_frame_pkg::LFSR_SEED;
    end else begin
      if (st_q == PRE) crc_q <= test_frame_pkg::CRC_INIT;
      else if (step && (st_q == HDR || st_q == PAY)) crc_q <= crc_byte(crc_q, cur_byte);
      if (step && st_q == PAY) lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13]
                                          ^ lfsr_q[12] ^ lfsr_q[10]};
    end
  end

  // Packet counters, restarted on each run
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i || start) begin
      pkts_q <= 32'h00000000;
      blk_q <= 14'h0000;
    end else if (step && st_q == FCS && st_d == GAP) begin
      pkts_q <= pkts_q + 32'h00000001;
      blk_q <= (blk_q == test_frame_pkg::BLOCK_PKTS - 14'h0001) ? 14'h0000 : blk_q + 14'h0001;
    end
  end

  test_frame_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .in_valid_i(emitting),
    .in_ready_o(fifo_ready),
    .in_data_i(fifo_in),
    .out_valid_o(fifo_valid),
    .out_ready_i(media_ready_i && (!out_valid_q || media_ready_i)),
    .out_data_o(fifo_out)
  );

  // Media output stage; idle flag follows the live control even in a stall
  wire next_valid = media_ready_i ? fifo_valid : out_valid_q;
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      out_valid_q <= 1'b0;
      out_data_q <= 8'h00;
    end else if (media_ready_i) begin
      out_valid_q <= fifo_valid;
      out_data_q <= fifo_valid ? fifo_out[8:1] : 8'h00;
    end
  end
  // low power idle when no frame byte
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) out_lpi_q <= 1'b0;
    else out_lpi_q <= !next_valid && force_lpi_i;
  end
  assign media_valid_o = out_valid_q;
  assign media_data_o = out_data_q;
  assign media_lpi_o = out_lpi_q;

  // Busy flag
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) busy_o <= 1'b0;
    else busy_o <= st_q != IDLE;
  end
  assign page_o = page_q;
endmodule

/* File: tb/media_sink.sv */
// Media-side partner: takes bytes, stalls one cycle in four.
// Assumes bytes move on a rising edge with valid and ready high.
module media_sink (
  input wire logic core_clk_i,
  input wire logic media_valid_i,
  input wire logic [7:0] media_data_i,
  output logic media_ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got[$];
  logic [1:0] cnt = 2'h0;
  initial media_ready_o = 1'b0;
  // isolated sink stands in for the link partner, no live network
  // Collect accepted bytes; ready changes just after the edge
  always @(posedge core_clk_i) begin
    if (media_valid_i && media_ready_o) begin
      got.push_back(media_data_i);
    end
    cnt <= cnt + 2'h1;
    media_ready_o <= (cnt != 2'h3);
  end
endmodule

/* File: tb/test_frame_source_properties.sv */
// Port checks for the test frame source.
// Assumes one clock and a synchronous active-low reset; bound below.
module test_frame_source_properties (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic mgmt_wr_i,
  input wire logic [4:0] mgmt_addr_i,
  input wire logic [15:0] mgmt_wdata_i,
  input wire logic [15:0] mgmt_rdata_o,
  input wire logic [15:0] page_o,
  input wire logic force_lpi_i,
  input wire logic media_valid_o,
  input wire logic [7:0] media_data_o,
  input wire logic media_lpi_o,
  input wire logic media_ready_i,
  input wire logic busy_o
);
  logic [15:0] pat_q;
  logic run_seen_q;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rstn_i);
  // Shadow of the pattern and of any run command
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      pat_q <= 16'h0000;
      run_seen_q <= 1'b0;
    end else if (mgmt_wr_i && page_o == 16'h0001) begin
      if (mgmt_addr_i == 5'h1e) begin
        pat_q <= mgmt_wdata_i;
      end
      if (mgmt_addr_i == 5'h1d && mgmt_wdata_i[15] && mgmt_wdata_i[14]) begin
        run_seen_q <= 1'b1;
      end
    end
  end
  a_page_write_lands: assert property (mgmt_wr_i && mgmt_addr_i == 5'h1f
    |=> page_o == $past(mgmt_wdata_i)) else $error("page not written");
  a_pattern_reads_back: assert property (page_o == 16'h0001 && mgmt_addr_i == 5'h1e
    && !mgmt_wr_i |=> mgmt_rdata_o == $past(pat_q)) else $error("pattern readback");
  a_low_addr_fixed: assert property (mgmt_addr_i < 5'h10 || (page_o != 16'h0001
    && mgmt_addr_i != 5'h1f) |=> mgmt_rdata_o == 16'h0000) else $error("unmapped read");
  a_stall_holds_byte: assert property (media_valid_o && !media_ready_i
    |=> media_valid_o && $stable(media_data_o)) else $error("byte dropped in stall");
  a_idle_data_zero: assert property (!media_valid_o |-> media_data_o == 8'h00)
    else $error("data while idle");
  a_lpi_when_forced: assert property (media_lpi_o |-> !media_valid_o
    && $past(force_lpi_i)) else $error("idle symbol misuse");
  a_send_after_run: assert property (media_valid_o |-> run_seen_q)
    else $error("sent without run");
  a_reset_quiet: assert property ($rose(rstn_i) |-> !media_valid_o && !busy_o
    && page_o == 16'h0000) else $error("outputs after reset");
endmodule
bind test_frame_source test_frame_source_properties i_test_frame_source_properties (
  .core_clk_i(core_clk_i), .rstn_i(rstn_i), .mgmt_wr_i(mgmt_wr_i), .mgmt_addr_i(mgmt_addr_i),
  .mgmt_wdata_i(mgmt_wdata_i), .mgmt_rdata_o(mgmt_rdata_o), .page_o(page_o),
  .force_lpi_i(force_lpi_i), .media_valid_o(media_valid_o), .media_data_o(media_data_o),
  .media_lpi_o(media_lpi_o), .media_ready_i(media_ready_i), .busy_o(busy_o));

/* File: tb/testbench.sv */
// Self-checking bench for the test frame source.
// Assumes the media_sink partner and a burst shortened to two frames.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [4:0] wa;
    logic [15:0] wd;
    logic [4:0] ra;
    logic [15:0] re;
    logic [15:0] pe;
  } row_s;
  row_s rows[8] = '{'{5'h1f, 16'h0002, 5'h1d, 16'h0000, 16'h0002},
    '{5'h1f, 16'h0003, 5'h1e, 16'h0000, 16'h0003}, '{5'h1f, 16'h0000, 5'h1d, 16'h0, 16'h0},
    '{5'h1f, 16'h0001, 5'h1e, 16'h0000, 16'h0001}, '{5'h1e, 16'h1234, 5'h1d, 16'h0040, 16'h1},
    '{5'h05, 16'h5555, 5'h05, 16'h0000, 16'h0001}, '{5'h1f, 16'h0002, 5'h1e, 16'h0, 16'h2},
    '{5'h1f, 16'h0001, 5'h1e, 16'h1234, 16'h0001}};
  logic core_clk_i, rstn_i, mgmt_wr_i, force_lpi_i, media_valid_o, media_lpi_o;
  logic media_ready_i, busy_o;
  logic [4:0] mgmt_addr_i;
  logic [15:0] mgmt_wdata_i, mgmt_rdata_o, page_o;
  logic [7:0] media_data_o;
  logic [7:0] exp_q[$];
  int n_errors = 0;
  int check_count = 0;
  int cycles = 0;
  int rbase;
  test_frame_source #(.BURST(2), .GAP_LONG(20)) i_test_frame_source (.core_clk_i(core_clk_i),
    .rstn_i(rstn_i), .mgmt_wr_i(mgmt_wr_i), .mgmt_addr_i(mgmt_addr_i),
    .mgmt_wdata_i(mgmt_wdata_i), .mgmt_rdata_o(mgmt_rdata_o), .page_o(page_o),
    .force_lpi_i(force_lpi_i), .media_valid_o(media_valid_o), .media_data_o(media_data_o),
    .media_lpi_o(media_lpi_o), .media_ready_i(media_ready_i), .busy_o(busy_o));
  media_sink i_media_sink (.core_clk_i(core_clk_i), .media_valid_i(media_valid_o),
    .media_data_i(media_data_o), .media_ready_o(media_ready_i));
  always #20 core_clk_i = ~core_clk_i;
  // Cut a hang short
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      results();
    end
  end
  task automatic results;
    if (n_errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic compare(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    mgmt_addr_i = a;
    mgmt_wdata_i = d;
    mgmt_wr_i = 1'b1;
    @(negedge core_clk_i) mgmt_wr_i = 1'b0;
    @(negedge core_clk_i);
  endtask
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] r;
    r = c ^ {24'h0, b};
    for (int k = 0; k < 8; k++) r = r[0] ? (r >> 1) ^ test_frame_pkg::CRC_POLY : r >> 1;
    return r;
  endfunction
  // Expected frame bytes, preamble through FCS
  task automatic frame(input int len, input logic bad);
    logic [31:0] c;
    logic [7:0] b;
    c = test_frame_pkg::CRC_INIT;
    repeat (7) exp_q.push_back(8'h55);
    exp_q.push_back(8'hd5);
    for (int i = 0; i < len - 4; i++) begin
      b = (i == 5) ? 8'hf3 : (i == 11) ? 8'hf5 : (i < 12) ? 8'hff : (i % 2) ? 8'h34 : 8'h12;
      c = crc_byte(c, b);
      exp_q.push_back(b);
    end
    if (!bad) c = ~c;
    for (int i = 0; i < 4; i++) exp_q.push_back(c[8*i+:8]);
  endtask
  // Rerun with new control, then compare the two-frame burst
  task automatic run_case(input logic [15:0] ctrl, input int len, input logic bad);
    int base;
    exp_q.delete();
    frame(len, bad);
    frame(len, bad);
    base = i_media_sink.got.size();
    wr(5'h1d, 16'h0000);
    wr(5'h1d, ctrl);
    for (int t = 0; t < 3000 && i_media_sink.got.size() < base + exp_q.size(); t++)
      @(negedge core_clk_i);
    for (int t = 0; t < 100 && busy_o !== 1'b0; t++) @(negedge core_clk_i);
    compare({15'h0, busy_o}, 16'h0000);
    repeat (300) @(negedge core_clk_i);
    compare(16'(i_media_sink.got.size() - base), 16'(exp_q.size()));
    foreach (exp_q[i]) compare({8'h0, i_media_sink.got[base+i]}, {8'h0, exp_q[i]});
  endtask
  initial begin
    core_clk_i = 1'b0;
    rstn_i = 1'b0;
    mgmt_wr_i = 1'b0;
    mgmt_addr_i = 5'h00;
    mgmt_wdata_i = 16'h0000;
    force_lpi_i = 1'b0;
    repeat (20) @(negedge core_clk_i);
    rstn_i = 1'b1;
    compare({13'h0, media_valid_o, busy_o, media_lpi_o}, 16'h0000);
    foreach (rows[i]) begin
      wr(rows[i].wa, rows[i].wd);
      mgmt_addr_i = rows[i].ra;
      @(negedge core_clk_i);
      compare(mgmt_rdata_o, rows[i].re);
      compare(page_o, rows[i].pe);
    end
    run_case(16'hc8d4, 64, 1'b0);
    run_case(16'hc0d5, 125, 1'b1);
    // Random payload with long gap: byte count and header checked
    rbase = i_media_sink.got.size();
    wr(5'h1d, 16'h0000);
    wr(5'h1d, 16'hcc42);
    repeat (600) @(negedge core_clk_i);
    compare(16'(i_media_sink.got.size() - rbase), 16'h0090);
    compare({8'h0, i_media_sink.got[rbase+13]}, 16'h00f1);
    compare({8'h0, i_media_sink.got[rbase+19]}, 16'h00f0);
    force_lpi_i = 1'b1;
    repeat (3) @(negedge core_clk_i);
    compare({15'h0, media_lpi_o}, 16'h0001);
    force_lpi_i = 1'b0;
    repeat (3) @(negedge core_clk_i);
    compare({15'h0, media_lpi_o}, 16'h0000);
    results();
  end
endmodule
